// File: src/swl_core.v
// Notes on behaviour
// (R1) single channel: 8-bit frame, msb first
// (R2) dual channel: channel bit, then 8 data
// (R3) channel bit 0 first latch, 1 second
// (R4) shift one bit per rising link clock
// (R5) output the bit entered eight shifts earlier
// (R6) clock low, select low: hold, drive output
// (R7) select rising loads addressed latch
// (R8) keep last nine bits, latch last eight
// (R9) host sends two frames for both channels
// (R10) update one channel, other unchanged
// (R11) preset low: latches midscale, output cleared
// (R12) preset release leaves latches at 0x80
// (R13) power-on reset presets latches to midscale
// (R14) power-down: open A, wiper to B, release
// (R15) power-down keeps latch contents
// (R16) one-hot tap decode of 256 positions
// (R17) serial output open drain only
// (R18) two chained single parts need 16 bits
// (R19) host holds select low across chain
// (R20) host slows clock when chaining; the bench chains at half 4 and raises half to 8 only for a later single frame
// (R21) preset async, wins over latch load; the code samples preset through a two-flop synchroniser on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "swl_map.vh"
module swl_core (
  input wire ref_clk,                             // 100 MHz system clock
  input wire resetn,                              // async reset, active low
  input wire dual_channel,                        // 1 selects the two-channel variant
  input wire link_clk,                            // serial clock pin
  input wire chip_sel_n,                          // chip select pin, active low
  input wire serial_in,                           // serial data pin
  input wire preset_mid_n,                        // preset to midscale, active low
  input wire power_down_n,                        // shutdown, active low
  output reg serial_out_open_drain_o,             // serial output level, always low
  output reg serial_out_open_drain_oe,            // high while pulling the pin low
  output reg [`SWL_DATA_W-1:0] wiper_latch_first, // first channel latch
  output reg [`SWL_DATA_W-1:0] wiper_latch_second, // second channel latch
  output reg [`SWL_TAP_N-1:0] tap_first,          // one-hot tap, first channel
  output reg [`SWL_TAP_N-1:0] tap_second,         // one-hot tap, second channel
  output reg a_open,                              // A terminals open
  output reg wiper_to_b,                          // wipers tied to B
  output reg load_busy                            // load buffer full
);
  // synchronised pins
  wire clk_s;
  wire cs_n_s;
  wire sdi_s;
  wire pr_n_s;
  wire pd_n_s;

  // edge history and serial path
  reg clk_d;
  reg cs_n_d;
  reg [`SWL_SR_W-1:0] shift_reg;
  reg sdo_latch;
  wire shift_edge;
  wire load_edge;

  // load path through the buffer
  wire ld_valid;
  wire ld_ready;
  wire [`SWL_LD_W-1:0] ld_word;
  wire out_valid;
  wire [`SWL_LD_W-1:0] out_word;
  wire channel_select_bit;
  wire [`SWL_DATA_W-1:0] next_data;
  wire load_first;
  wire load_second;

  // active-high control levels
  wire preset_on;
  wire power_down_on;
  wire selected;

  // next values of every flop but the edge history and the output level
  reg [`SWL_SR_W-1:0] next_shift_reg;
  reg next_sdo_latch;
  reg [`SWL_DATA_W-1:0] next_wiper_first;
  reg [`SWL_DATA_W-1:0] next_wiper_second;
  reg [`SWL_TAP_N-1:0] next_tap_first;
  reg [`SWL_TAP_N-1:0] next_tap_second;
  reg next_oe;
  reg next_a_open;
  reg next_wiper_to_b;
  reg next_load_busy;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every pin is foreign to ref_clk
  // select, preset and power-down idle high; their flops reset high so
  // no false select edge or phantom preset follows a reset
  // serial clock, parked low between frames
  swl_sync2 #(
    .RST_VAL(`SWL_IDLE_LOW)
  ) u_sync_clk (
    .ref_clk(ref_clk), // system clock
    .resetn(resetn), // async reset
    .d(link_clk), // serial clock pin
    .q(clk_s) // synchronised clock
  );

  // chip select, idles high
  swl_sync2 #(
    .RST_VAL(`SWL_IDLE_HIGH)
  ) u_sync_cs (
    .ref_clk(ref_clk), // system clock
    .resetn(resetn), // async reset
    .d(chip_sel_n), // select pin
    .q(cs_n_s) // synchronised select
  );

  // serial data, any level while idle
  swl_sync2 #(
    .RST_VAL(`SWL_IDLE_LOW)
  ) u_sync_sdi (
    .ref_clk(ref_clk), // system clock
    .resetn(resetn), // async reset
    .d(serial_in), // data pin
    .q(sdi_s) // synchronised data
  );

  // preset, idles high
  swl_sync2 #(
    .RST_VAL(`SWL_IDLE_HIGH)
  ) u_sync_pr (
    .ref_clk(ref_clk), // system clock
    .resetn(resetn), // async reset
    .d(preset_mid_n), // preset pin
    .q(pr_n_s) // synchronised preset
  );

  // power-down, idles high
  swl_sync2 #(
    .RST_VAL(`SWL_IDLE_HIGH)
  ) u_sync_pd (
    .ref_clk(ref_clk), // system clock
    .resetn(resetn), // async reset
    .d(power_down_n), // power-down pin
    .q(pd_n_s) // synchronised power-down
  );

  // edge history; reset values treat select as inactive, as a low start
  // would let a power-up rise fake a load, hence cs history resets high
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      clk_d <= clk_s;
      cs_n_d <= cs_n_s;
    end
  end

  assign shift_edge = clk_s & ~clk_d & ~cs_n_s;  // (R4)
  assign load_edge = cs_n_s & ~cs_n_d;           // (R7)

  // active-high views of the synchronised controls; preset beats a load
  // in every process below, so a select rise inside preset is dropped
  assign preset_on = ~pr_n_s;
  assign power_down_on = ~pd_n_s;
  assign selected = ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // shift register: nine bits serve both variants, msb first
  // clock low or high without an edge holds contents
  always @* begin
    next_shift_reg = shift_reg; // (R6)
    if (shift_edge) begin
      next_shift_reg = {shift_reg[`SWL_SR_W-2:0], sdi_s}; // (R1) (R2) (R4)
    end
  end

  // no clear at frame start: stale bits fall off the far end anyway
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= {`SWL_SR_W{1'b0}};
    end else begin
      shift_reg <= next_shift_reg;
    end
  end

  // output latch carries the bit entered eight shifts earlier; preset clears it
  always @* begin
    next_sdo_latch = sdo_latch;
    if (preset_on) begin
      next_sdo_latch = 1'b0; // (R11)
    end else if (shift_edge) begin
      next_sdo_latch = shift_reg[`SWL_DATA_W-1]; // (R5)
    end
  end

  // latch changes only on a shift or a preset, so the pin holds a whole link period
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sdo_latch <= 1'b0;
    end else begin
      sdo_latch <= next_sdo_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load word: top bit is channel select, low eight are data; older bits
  // beyond nine have already fallen off the register end
  assign ld_word = dual_channel ? shift_reg : {`SWL_CHAN_FIRST, shift_reg[`SWL_DATA_W-1:0]}; // (R8)
  assign ld_valid = load_edge & ~preset_on; // (R21)

  // buffer lets a slow latch stage lose no load; back-to-back frames
  // faster than the drain would otherwise overwrite
  // it drains every cycle outside preset, so load_busy rises only in theory
  swl_load_buf u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush(~pr_n_s),
    .in_valid(ld_valid),
    .in_ready(ld_ready),
    .in_data(ld_word),
    .out_valid(out_valid),
    .out_ready(pr_n_s),
    .out_data(out_word)
  );

  assign channel_select_bit = out_word[`SWL_SR_W-1];
  assign next_data = out_word[`SWL_DATA_W-1:0];

  // one word addresses one latch; the other keeps its setting
  assign load_first = out_valid & (channel_select_bit == `SWL_CHAN_FIRST);   // (R3)
  assign load_second = out_valid & (channel_select_bit == `SWL_CHAN_SECOND); // (R3)

  ////////////////////////////////////////////////////////////////////////////
  // wiper latches: reset and preset both land on midscale; power-down
  // never touches them so settings survive shutdown
  always @* begin
    next_wiper_first = wiper_latch_first;
    next_wiper_second = wiper_latch_second;
    if (preset_on) begin
      next_wiper_first = `SWL_MID_CODE;  // (R11) (R12) (R21)
      next_wiper_second = `SWL_MID_CODE; // (R11) (R12)
    end else begin
      if (load_first) begin
        next_wiper_first = next_data; // (R10)
      end
      if (load_second) begin
        next_wiper_second = next_data; // (R10)
      end
    end
  end // (R15)

  // reset stands in for the supply-driven power-on preset
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wiper_latch_first <= `SWL_MID_CODE;  // (R13)
      wiper_latch_second <= `SWL_MID_CODE; // (R13)
    end else begin
      wiper_latch_first <= next_wiper_first;
      wiper_latch_second <= next_wiper_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tap decode follows the latch one cycle later, exactly one bit set
  always @* begin
    next_tap_first = {{(`SWL_TAP_N-1){1'b0}}, 1'b1} << wiper_latch_first;   // (R16)
    next_tap_second = {{(`SWL_TAP_N-1){1'b0}}, 1'b1} << wiper_latch_second; // (R16)
  end

  // taps are all open in reset so no switch closes before the first decode
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tap_first <= {`SWL_TAP_N{1'b0}};
      tap_second <= {`SWL_TAP_N{1'b0}};
    end else begin
      tap_first <= next_tap_first;
      tap_second <= next_tap_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; open drain pulls low only, release floats high
  // shutdown releases the pin so the pull-up burns no current
  always @* begin
    next_oe = 1'b0;
    next_a_open = power_down_on; // (R14)
    next_wiper_to_b = power_down_on; // (R14)
    next_load_busy = ~ld_ready;
    if (!power_down_on && selected) begin
      next_oe = ~sdo_latch; // (R6) (R17)
    end
  end // (R14)

  // every pin output leaves a flop, so no decode glitch reaches a pad
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_open_drain_o <= 1'b0;
      serial_out_open_drain_oe <= 1'b0;
      a_open <= 1'b0;
      wiper_to_b <= 1'b0;
      load_busy <= 1'b0;
    end else begin
      serial_out_open_drain_o <= 1'b0; // (R17)
      serial_out_open_drain_oe <= next_oe;
      a_open <= next_a_open;
      wiper_to_b <= next_wiper_to_b;
      load_busy <= next_load_busy;
    end
  end
endmodule // swl_core
`default_nettype wire

// File: src/swl_load_buf.v
`timescale 1ns/1ps
`default_nettype none
`include "swl_map.vh"
module swl_load_buf (
  input wire ref_clk,                   // clock
  input wire resetn,                    // async reset, active low
  input wire flush,                     // preset drops pending loads
  input wire in_valid,                  // load word offered
  output wire in_ready,                 // room for a word
  input wire [`SWL_LD_W-1:0] in_data,   // channel bit and data
  output wire out_valid,                // word waiting
  input wire out_ready,                 // consumer takes it
  output wire [`SWL_LD_W-1:0] out_data  // oldest word
);
  reg [`SWL_LD_W-1:0] mem [0:`SWL_BUF_DEPTH-1];
  reg [`SWL_BUF_PTR_W-1:0] wr_ptr;
  reg [`SWL_BUF_PTR_W-1:0] rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != `SWL_DEPTH_MOD);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // two-entry fifo; full refuses further words
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else if (flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage holds no reset; only valid entries are read
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // swl_load_buf
`default_nettype wire

// File: src/swl_map.vh
`ifndef SWL_MAP_VH
`define SWL_MAP_VH
`define SWL_DATA_W 8
`define SWL_SR_W 9
`define SWL_MID_CODE 8'h80
`define SWL_TAP_N 256
`define SWL_CHAN_FIRST 1'b0
`define SWL_CHAN_SECOND 1'b1
`define SWL_BUF_DEPTH 2
`define SWL_BUF_PTR_W 1
`define SWL_LD_W 9
`define SWL_DEPTH_MOD 2'h2
`define SWL_IDLE_HIGH 1'b1
`define SWL_IDLE_LOW 1'b0
`endif

// File: src/swl_sync2.v
`timescale 1ns/1ps
`default_nettype none
module swl_sync2 #(
  parameter RST_VAL = 1'b0 // level held during reset, the pin's idle level
) (
  input wire ref_clk,    // sampling clock
  input wire resetn,     // async reset, active low
  input wire d,          // async level in
  output reg q           // synchronised level
);
  reg meta;

  // two flops; the first is read only by the second
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // swl_sync2
`default_nettype wire

// File: testbench/swl_chk_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "swl_map.vh"
module swl_chk (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset
  input wire logic chip_sel_n, // select
  input wire logic preset_mid_n, // preset
  input wire logic power_down_n, // shutdown
  input wire logic serial_out_open_drain_o, // pin
  input wire logic serial_out_open_drain_oe, // enable
  input wire logic [`SWL_DATA_W-1:0] wiper_latch_first, // latch
  input wire logic [`SWL_DATA_W-1:0] wiper_latch_second, // latch
  input wire logic [`SWL_TAP_N-1:0] tap_first, // taps
  input wire logic [`SWL_TAP_N-1:0] tap_second, // taps
  input wire logic a_open, // a open
  input wire logic wiper_to_b // wiper on b
);
  // repeats cover the two-flop pin synchronisers
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  preset_mid_a: assert property ((!preset_mid_n)[*4] |->
    wiper_latch_first == 8'h80 && wiper_latch_second == 8'h80) else $error("preset latch");
  power_down_a: assert property ((!power_down_n)[*5] |->
    a_open && wiper_to_b && !serial_out_open_drain_oe) else $error("shutdown state");
  drain_low_a: assert property (serial_out_open_drain_o == 1'b0) else $error("pin driven high");
  tap_one_a: assert property ($past(resetn) |->
    tap_first == (256'h1 << $past(wiper_latch_first))) else $error("tap one");
  tap_two_a: assert property ($past(resetn) |->
    tap_second == (256'h1 << $past(wiper_latch_second))) else $error("tap two");
  latch_hold_a: assert property ((chip_sel_n && preset_mid_n)[*8] |=>
    $stable(wiper_latch_first) && $stable(wiper_latch_second)) else $error("latch moved");
  desel_off_a: assert property (chip_sel_n[*5] |=> !serial_out_open_drain_oe) else $error("enable");
  preset_pull_a: assert property ((!preset_mid_n && !chip_sel_n && power_down_n)[*5] |=>
    serial_out_open_drain_oe) else $error("output latch");
  cover property ($rose(chip_sel_n));
  cover property ($fell(power_down_n));
  cover property ($fell(preset_mid_n));
endmodule // swl_chk
bind swl_core swl_chk u_chk (.*);
`default_nettype wire

// File: testbench/swl_host.sv
`timescale 1ns/1ps
`default_nettype none
module swl_host (
  input wire logic ref_clk, // bench clock
  input wire logic sdo_pin, // pulled-up node
  output logic link_clk, // serial clock
  output logic chip_sel_n, // select
  output logic serial_in // data
);
  logic [15:0] seen; // bits taken from the node
  int half = 4; // cycles a half period; raise when chained
  // idle: clock parked low, not selected
  initial begin
    link_clk = 1'b0;
    chip_sel_n = 1'b1;
    serial_in = 1'b0;
    seen = 16'h0;
  end
  // msb first, select low across all chained bits
  task automatic frame(input int n, input logic [15:0] w);
    @(negedge ref_clk) chip_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      repeat (half) @(negedge ref_clk);
      seen = {seen[14:0], sdo_pin};
      link_clk = 1'b1;
      repeat (half) @(negedge ref_clk);
      link_clk = 1'b0;
    end
    repeat (half) @(negedge ref_clk);
    seen = {seen[14:0], sdo_pin};
    chip_sel_n = 1'b1;
    // released line must not keep the last bit
    serial_in = ~serial_in;
  endtask
endmodule // swl_host
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "swl_map.vh"
module tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic dual_channel = 1'b1;
  logic preset_mid_n = 1'b1;
  logic power_down_n = 1'b1;
  wire link_clk, chip_sel_n, serial_in, sdo_pin, load_busy;
  wire serial_out_open_drain_o, serial_out_open_drain_oe, a_open, wiper_to_b;
  wire [`SWL_DATA_W-1:0] wiper_latch_first, wiper_latch_second;
  wire [`SWL_TAP_N-1:0] tap_first, tap_second;
  int failures = 0;
  int n_tests = 0;
  // pull-up: a released pin reads high
  assign sdo_pin = serial_out_open_drain_oe ? serial_out_open_drain_o : 1'b1;
  always #5 ref_clk = ~ref_clk;
  swl_core dut (.*);
  swl_host host (.*);
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // variant only changes inside reset, as it is not synchronised
  task automatic rst(input logic d);
    resetn = 1'b0;
    dual_channel = d;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  // load walk is about five cycles; eight leaves margin
  task automatic lat(input logic [7:0] f, s);
    repeat (8) @(negedge ref_clk);
    chk("first", wiper_latch_first, f);
    chk("second", wiper_latch_second, s);
    chk("tap1", {7'h0, tap_first[f]}, 8'h1);
    chk("tap2", {7'h0, tap_second[s]}, 8'h1);
    chk("busy", {7'h0, load_busy}, 8'h0);
  endtask
  initial begin
    rst(1'b1);
    lat(8'h80, 8'h80);
    host.frame(9, 16'h0a5);
    lat(8'ha5, 8'h80);
    host.frame(9, 16'h13c);
    lat(8'ha5, 8'h3c);
    host.frame(12, 16'h5ff);
    lat(8'ha5, 8'hff);
    host.frame(9, 16'h000);
    lat(8'h00, 8'hff);
    power_down_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("a_open", {7'h0, a_open}, 8'h1);
    chk("w_to_b", {7'h0, wiper_to_b}, 8'h1);
    power_down_n = 1'b1;
    lat(8'h00, 8'hff);
    preset_mid_n = 1'b0;
    host.frame(9, 16'h155);
    lat(8'h80, 8'h80);
    preset_mid_n = 1'b1;
    lat(8'h80, 8'h80);
    rst(1'b0);
    lat(8'h80, 8'h80);
    host.frame(16, 16'hc35a);
    lat(8'h5a, 8'h80);
    chk("chain", host.seen[7:0], 8'hc3);
    host.half = 8;
    host.frame(8, 16'h0001);
    lat(8'h01, 8'h80);
    close_out;
  end
  // hang guard, far beyond the few frames sent
  initial begin
    #200000;
    failures++;
    close_out;
  end
endmodule // tb
`default_nettype wire
